/* verilog/memcfg.sv */
// Memory configuration block: two APB registers and the access timing.
// Assumes APB master on sys_clk and asynchronous external pins.
//
// Overview of operation
// - PROM bus-ready enable holds PROM accesses until bus-ready arrives.
// - Async bus-ready adds a sampling stage; access ends one clock later.
// - I/O width code 00 gives 8 bits, code 10 gives 32 bits.
// - I/O bus-ready enable extends I/O accesses until bus-ready arrives.
// - Enabled bus-error ends access with error and type-dependent trap.
// - I/O accesses insert the four-bit I/O waitstate count.
// - I/O accesses are refused while the I/O enable bit is zero.
// - PROM writes happen only when PROM write enable is set.
// - PROM width 00 is 8 bits, upper bit set means 32 bits.
// - Reset loads PROM width from general-purpose pins one and zero.
// - PROM write waitstates are twice the field; reset sets maximum.
// - PROM read waitstates are twice the field; reset sets maximum.
// - Eight-bit PROM with checking refuses the last fifth of a bank.
// - Periodic SDRAM refresh only while refresh enable is set.
// - Precharge lasts 2 clocks, or 3 with the timing bit set.
// - Refresh cycle lasts three clocks plus the refresh field.
// - CAS bit selects latency 2 or 3 and row-to-column delay.
// - SDRAM bank size doubles per code from 4 MB to 512 MB.
// - Column code gives 256/512/1024; code 11 gives 4096 or 2048.
// - Nonzero command field issues its command, then clears itself.
// - SDRAM enable turns on the controller; with disable, SRAM is off.
`timescale 1ns/1ps
`default_nettype none
module memcfg (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // External pins.
    input  wire logic        ext_bus_ready_n,
    input  wire logic        ext_bus_error_n,
    input  wire logic [1:0]  general_purpose_pins,
    // Memory access requests.
    input  wire logic        acc_req,
    input  wire logic [1:0]  acc_area,
    input  wire logic        acc_write,
    input  wire logic        acc_fetch,
    input  wire logic [31:0] acc_addr,
    input  wire logic        prom_edac_en,
    output logic             acc_done,
    output logic             acc_err,
    output logic             acc_trap,
    output logic      [7:0]  acc_trap_code,
    // Bus geometry.
    output logic             prom_bus_32,
    output logic             io_bus_32,
    // SDRAM control.
    output logic             sdram_cmd_strobe,
    output logic      [1:0]  sdram_cmd,
    output logic             sdram_busy,
    output logic             sdram_ctrl_en,
    output logic             sram_disable,
    output logic      [1:0]  cas_latency,
    output logic      [1:0]  ras_cas_delay,
    output logic      [31:0] sdram_bank_bytes,
    output logic      [12:0] sdram_columns
);
    // --------------------------------------------------------------
    // Pin synchronisation.
    // --------------------------------------------------------------
    logic [3:0] pins_s;
    logic       ext_bus_ready_n_late_q;
    logic       ext_bus_ready_n_s;
    logic       bexc_s;
    logic       ext_bus_ready_n_ok;
    logic       cfg_abrdy;

    pin_sync #(.WIDTH(4)) u_sync (
        .sys_clk   (sys_clk),
        .pin_async ({ext_bus_ready_n, ext_bus_error_n,
                     general_purpose_pins}),
        .pin_sync  (pins_s)
    );
    assign ext_bus_ready_n_s = !pins_s[3];
    assign bexc_s = !pins_s[2];

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ext_bus_ready_n_late_q <= 1'b0;
        end else begin
            ext_bus_ready_n_late_q <= ext_bus_ready_n_s;
        end
    end
    assign ext_bus_ready_n_ok = pins_s[3] ? 1'b0 :
                     (cfg_abrdy ? ext_bus_ready_n_late_q : 1'b1);

    // --------------------------------------------------------------
    // Register file.
    // --------------------------------------------------------------
    logic [31:0] cfg1_q;
    logic [31:0] cfg2_q;
    logic [31:0] prdata_q;
    logic        pslverr_q;
    logic        wr_en;
    logic        cmd_done;
    logic [7:0]  ofs;

    assign ofs   = {paddr[7:2], 2'b00};
    assign wr_en = psel && penable && pwrite;
    assign cfg_abrdy = cfg1_q[memcfg_pkg::B_ABRDY];

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cfg1_q <= memcfg_pkg::CFG1_RST;
            cfg1_q[memcfg_pkg::B_PRWDH +: 2] <= pins_s[1:0];
        end else if (wr_en && ofs == memcfg_pkg::OFS_PROM_IO) begin
            cfg1_q <= pwdata & memcfg_pkg::CFG1_MASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cfg2_q <= memcfg_pkg::CFG2_RST;
        end else if (wr_en && ofs == memcfg_pkg::OFS_SDRAM) begin
            cfg2_q <= pwdata & memcfg_pkg::CFG2_MASK;
        end else if (cmd_done) begin
            cfg2_q[memcfg_pkg::B_SDRCMD +: 2] <= memcfg_pkg::CMD_NONE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (psel && !penable) begin
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            case (ofs)
                memcfg_pkg::OFS_PROM_IO: prdata_q <= cfg1_q;
                memcfg_pkg::OFS_SDRAM:   prdata_q <= cfg2_q;
                default:                 pslverr_q <= 1'b1;
            endcase
        end
    end
    assign prdata  = prdata_q;
    assign pready  = psel && penable;
    assign pslverr = pslverr_q && psel && penable;

    // --------------------------------------------------------------
    // Static access sequencer.
    // --------------------------------------------------------------
    memcfg_pkg::acc_state_t acc_st_q;
    logic [4:0] ws_cnt_q;
    logic [4:0] acc_ws;
    logic [1:0] area_q;
    logic       wr_q;
    logic       fetch_q;
    logic       acc_take;
    logic       acc_block;
    logic       check_zone;
    logic       ext_bus_ready_n_need;
    logic       bexc_hit;
    logic [7:0] trap_sel;

    function automatic logic [4:0] twice(input logic [3:0] f);
        twice = {f, 1'b0};
    endfunction

    assign acc_take = acc_req && acc_st_q == memcfg_pkg::ACC_IDLE &&
                      !acc_done;
    assign check_zone = (acc_addr & (memcfg_pkg::PROM_BANK_BYTES -
                         32'h0000_0001)) >= memcfg_pkg::PROM_CHECK_BASE;
    assign acc_block =
        (acc_area == memcfg_pkg::AREA_IO &&
         !cfg1_q[memcfg_pkg::B_IOEN]) ||
        (acc_area == memcfg_pkg::AREA_PROM && acc_write &&
         !cfg1_q[memcfg_pkg::B_PRWEN]) ||
        (acc_area == memcfg_pkg::AREA_PROM && !prom_bus_32 &&
         prom_edac_en && check_zone) ||
        (acc_area == memcfg_pkg::AREA_RAM && sdram_ctrl_en &&
         sram_disable);

    always_comb begin
        acc_ws = 5'h00;
        if (acc_area == memcfg_pkg::AREA_IO) begin
            acc_ws = {1'b0, cfg1_q[memcfg_pkg::B_IOWS +: 4]};
        end else if (acc_area == memcfg_pkg::AREA_PROM) begin
            acc_ws = acc_write ?
                twice(cfg1_q[memcfg_pkg::B_PRWWS +: 4]) :
                twice(cfg1_q[memcfg_pkg::B_PRRWS +: 4]);
        end
    end

    assign ext_bus_ready_n_need =
        (area_q == memcfg_pkg::AREA_PROM &&
         cfg1_q[memcfg_pkg::B_PBRDY]) ||
        (area_q == memcfg_pkg::AREA_IO &&
         cfg1_q[memcfg_pkg::B_IOBRDY]);
    assign bexc_hit = bexc_s && cfg1_q[memcfg_pkg::B_BEXC];
    assign trap_sel = fetch_q ? memcfg_pkg::TRAP_FETCH :
                      (wr_q ? memcfg_pkg::TRAP_STORE :
                       memcfg_pkg::TRAP_LOAD);

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            acc_st_q      <= memcfg_pkg::ACC_IDLE;
            ws_cnt_q      <= 5'h00;
            area_q        <= memcfg_pkg::AREA_RAM;
            wr_q          <= 1'b0;
            fetch_q       <= 1'b0;
            acc_done      <= 1'b0;
            acc_err       <= 1'b0;
            acc_trap      <= 1'b0;
            acc_trap_code <= 8'h00;
        end else begin
            acc_done <= 1'b0;
            acc_err  <= 1'b0;
            acc_trap <= 1'b0;
            case (acc_st_q)
                memcfg_pkg::ACC_IDLE: begin
                    if (acc_take) begin
                        area_q  <= acc_area;
                        wr_q    <= acc_write;
                        fetch_q <= acc_fetch;
                        if (acc_block) begin
                            acc_done <= 1'b1;
                            acc_err  <= 1'b1;
                        end else begin
                            ws_cnt_q <= acc_ws;
                            acc_st_q <= memcfg_pkg::ACC_WAIT;
                        end
                    end
                end
                memcfg_pkg::ACC_WAIT: begin
                    if (bexc_hit) begin
                        acc_done      <= 1'b1;
                        acc_err       <= 1'b1;
                        acc_trap      <= 1'b1;
                        acc_trap_code <= trap_sel;
                        acc_st_q      <= memcfg_pkg::ACC_IDLE;
                    end else if (ws_cnt_q != 5'h00) begin
                        ws_cnt_q <= ws_cnt_q - 5'h01;
                    end else if (!ext_bus_ready_n_need || ext_bus_ready_n_ok) begin
                        acc_done <= 1'b1;
                        acc_st_q <= memcfg_pkg::ACC_IDLE;
                    end
                end
                default: acc_st_q <= memcfg_pkg::ACC_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Geometry decode.
    // --------------------------------------------------------------
    assign prom_bus_32 = cfg1_q[memcfg_pkg::B_PRWDH + 1];
    assign io_bus_32   = cfg1_q[memcfg_pkg::B_IOWDH +: 2] ==
                         memcfg_pkg::WDH_32;
    assign sdram_ctrl_en = cfg2_q[memcfg_pkg::B_SE];
    assign sram_disable  = cfg2_q[memcfg_pkg::B_SI];
    assign cas_latency   = cfg2_q[memcfg_pkg::B_CAS] ?
        memcfg_pkg::CAS_LONG : memcfg_pkg::CAS_SHORT;
    assign ras_cas_delay = cas_latency;
    assign sdram_bank_bytes = memcfg_pkg::SDRAM_BANK_MIN <<
        cfg2_q[memcfg_pkg::B_SDRBS +: 3];

    always_comb begin
        case (cfg2_q[memcfg_pkg::B_SDRCLS +: 2])
            2'h0:    sdram_columns = memcfg_pkg::COLS_256;
            2'h1:    sdram_columns = memcfg_pkg::COLS_512;
            2'h2:    sdram_columns = memcfg_pkg::COLS_1024;
            default: sdram_columns =
                (cfg2_q[memcfg_pkg::B_SDRBS +: 3] == 3'h7) ?
                memcfg_pkg::COLS_4096 : memcfg_pkg::COLS_2048;
        endcase
    end

    // --------------------------------------------------------------
    // SDRAM command engine and refresh timer.
    // --------------------------------------------------------------
    memcfg_pkg::sd_state_t sd_st_q;
    logic [9:0] ref_cnt_q;
    logic       ref_pend_q;
    logic       ref_en;
    logic [1:0] sw_cmd;
    logic [1:0] start_kind;
    logic [3:0] sd_dur;
    logic [3:0] sd_cnt_q;
    logic       sw_q;
    logic       sd_start;
    logic       sd_done;

    assign ref_en   = cfg2_q[memcfg_pkg::B_SDRREF] && sdram_ctrl_en;
    assign sw_cmd   = cfg2_q[memcfg_pkg::B_SDRCMD +: 2];
    assign sd_start = sd_st_q == memcfg_pkg::SD_IDLE && sdram_ctrl_en &&
                      (sw_cmd != memcfg_pkg::CMD_NONE ||
                       (ref_pend_q && ref_en));
    assign start_kind = (sw_cmd != memcfg_pkg::CMD_NONE) ? sw_cmd :
                        memcfg_pkg::CMD_REF;
    assign sd_done  = sd_st_q == memcfg_pkg::SD_BUSY && sd_cnt_q == 4'h0;
    assign cmd_done = sd_done && sw_q;
    assign sdram_busy = sd_st_q == memcfg_pkg::SD_BUSY;

    always_comb begin
        case (start_kind)
            memcfg_pkg::CMD_PRE: sd_dur = cfg2_q[memcfg_pkg::B_TRP] ?
                memcfg_pkg::TRP_LONG : memcfg_pkg::TRP_SHORT;
            memcfg_pkg::CMD_REF: sd_dur = memcfg_pkg::TRFC_BASE +
                {1'b0, cfg2_q[memcfg_pkg::B_TRFC +: 3]};
            default: sd_dur = memcfg_pkg::LMR_CYCLES;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ref_cnt_q  <= memcfg_pkg::REFRESH_CYCLES;
            ref_pend_q <= 1'b0;
        end else begin
            ref_cnt_q <= (ref_cnt_q == 10'h000) ?
                memcfg_pkg::REFRESH_CYCLES : ref_cnt_q - 10'h001;
            if (ref_cnt_q == 10'h000 && ref_en) begin
                ref_pend_q <= 1'b1;
            end else if (!ref_en || (sd_start &&
                         sw_cmd == memcfg_pkg::CMD_NONE)) begin
                ref_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sd_st_q          <= memcfg_pkg::SD_IDLE;
            sd_cnt_q         <= 4'h0;
            sw_q             <= 1'b0;
            sdram_cmd        <= memcfg_pkg::CMD_NONE;
            sdram_cmd_strobe <= 1'b0;
        end else begin
            sdram_cmd_strobe <= 1'b0;
            case (sd_st_q)
                memcfg_pkg::SD_IDLE: begin
                    if (sd_start) begin
                        sd_cnt_q  <= sd_dur - 4'h1;
                        sw_q      <= sw_cmd != memcfg_pkg::CMD_NONE;
                        sdram_cmd <= start_kind;
                        sdram_cmd_strobe <= 1'b1;
                        sd_st_q   <= memcfg_pkg::SD_BUSY;
                    end
                end
                memcfg_pkg::SD_BUSY: begin
                    if (sd_cnt_q == 4'h0) begin
                        sd_st_q <= memcfg_pkg::SD_IDLE;
                    end else begin
                        sd_cnt_q <= sd_cnt_q - 4'h1;
                    end
                end
                default: sd_st_q <= memcfg_pkg::SD_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Checks.
    // --------------------------------------------------------------
    logic [5:0] acc_cyc_q;
    logic [3:0] sd_cyc_q;

    always_ff @(posedge sys_clk) begin
        if (!nrst || acc_take) begin
            acc_cyc_q <= 6'h00;
        end else if (acc_cyc_q != 6'h3f) begin
            acc_cyc_q <= acc_cyc_q + 6'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst || sd_start) begin
            sd_cyc_q <= 4'h1;
        end else if (sdram_busy) begin
            sd_cyc_q <= sd_cyc_q + 4'h1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    sequence s_pre_start;
        sd_start && start_kind == memcfg_pkg::CMD_PRE;
    endsequence

    chk_io_refused: assert property (
        acc_take && acc_area == memcfg_pkg::AREA_IO &&
        !cfg1_q[memcfg_pkg::B_IOEN] |=> acc_done && acc_err)
        else $error("I/O access not refused while disabled");
    chk_prom_wr_block: assert property (
        acc_take && acc_area == memcfg_pkg::AREA_PROM && acc_write &&
        !cfg1_q[memcfg_pkg::B_PRWEN] |=> acc_err)
        else $error("PROM write not refused");
    chk_ext_bus_ready_n_hold: assert property (
        acc_st_q == memcfg_pkg::ACC_WAIT && ws_cnt_q == 5'h00 &&
        ext_bus_ready_n_need && !ext_bus_ready_n_s && !bexc_hit |=> !acc_done)
        else $error("access ended without bus ready");
    chk_io_waits: assert property (
        acc_done && !acc_err && area_q == memcfg_pkg::AREA_IO &&
        !cfg1_q[memcfg_pkg::B_IOBRDY] |->
        acc_cyc_q == {2'b00, cfg1_q[memcfg_pkg::B_IOWS +: 4]} + 6'h01)
        else $error("wrong I/O waitstate count");
    chk_prom_rd_waits: assert property (
        acc_done && !acc_err && area_q == memcfg_pkg::AREA_PROM &&
        !wr_q && !cfg1_q[memcfg_pkg::B_PBRDY] |->
        acc_cyc_q == {1'b0, twice(cfg1_q[memcfg_pkg::B_PRRWS +: 4])} +
        6'h01)
        else $error("wrong PROM read waitstate count");
    chk_bexc_trap: assert property (
        acc_st_q == memcfg_pkg::ACC_WAIT && bexc_hit |=>
        acc_trap && acc_err && acc_trap_code == $past(trap_sel))
        else $error("bus error gave no trap");
    chk_trp_short: assert property (
        s_pre_start and !cfg2_q[memcfg_pkg::B_TRP] |->
        ##1 (!sd_done)[*1] ##1 sd_done)
        else $error("short precharge length wrong");
    chk_trp_long: assert property (
        s_pre_start and cfg2_q[memcfg_pkg::B_TRP] |->
        ##1 (!sd_done)[*2] ##1 sd_done)
        else $error("long precharge length wrong");
    chk_trfc_len: assert property (
        sd_done && sdram_cmd == memcfg_pkg::CMD_REF |->
        sd_cyc_q == memcfg_pkg::TRFC_BASE +
        {1'b0, cfg2_q[memcfg_pkg::B_TRFC +: 3]})
        else $error("refresh cycle length wrong");
    chk_refresh_gate: assert property (
        sdram_cmd_strobe && sdram_cmd == memcfg_pkg::CMD_REF && !sw_q |->
        $past(cfg2_q[memcfg_pkg::B_SDRREF]))
        else $error("refresh issued while disabled");
    chk_cmd_clear: assert property (
        cmd_done && !wr_en |=> sw_cmd == memcfg_pkg::CMD_NONE)
        else $error("command field not cleared");
endmodule
`default_nettype wire

/* verilog/memcfg_pkg.sv */
// Constants of the memory configuration block: offsets, fields, codes.
// Assumes a 50 MHz system clock and an APB register window.
package memcfg_pkg;
    // --------------------------------------------------------------
    // Register offsets and storage masks.
    // --------------------------------------------------------------
    localparam logic [7:0]  OFS_PROM_IO = 8'h00;
    localparam logic [7:0]  OFS_SDRAM   = 8'h04;
    localparam logic [31:0] CFG1_MASK   = 32'h7ef8_0bff;
    localparam logic [31:0] CFG1_RST    = 32'h0000_00ff;
    localparam logic [31:0] CFG2_MASK   = 32'hfff8_6000;
    localparam logic [31:0] CFG2_RST    = 32'h7c40_0000;
    // --------------------------------------------------------------
    // Field positions.
    // --------------------------------------------------------------
    localparam int B_PBRDY  = 30;
    localparam int B_ABRDY  = 29;
    localparam int B_IOWDH  = 27;
    localparam int B_IOBRDY = 26;
    localparam int B_BEXC   = 25;
    localparam int B_IOWS   = 20;
    localparam int B_IOEN   = 19;
    localparam int B_PRWEN  = 11;
    localparam int B_PRWDH  = 8;
    localparam int B_PRWWS  = 4;
    localparam int B_PRRWS  = 0;
    localparam int B_SDRREF = 31;
    localparam int B_TRP    = 30;
    localparam int B_TRFC   = 27;
    localparam int B_CAS    = 26;
    localparam int B_SDRBS  = 23;
    localparam int B_SDRCLS = 21;
    localparam int B_SDRCMD = 19;
    localparam int B_SE     = 14;
    localparam int B_SI     = 13;
    // --------------------------------------------------------------
    // Codes.
    // --------------------------------------------------------------
    localparam logic [1:0] AREA_RAM  = 2'h0;
    localparam logic [1:0] AREA_PROM = 2'h1;
    localparam logic [1:0] AREA_IO   = 2'h2;
    localparam logic [1:0] WDH_8     = 2'h0;
    localparam logic [1:0] WDH_32    = 2'h2;
    localparam logic [1:0] CMD_NONE  = 2'h0;
    localparam logic [1:0] CMD_PRE   = 2'h1;
    localparam logic [1:0] CMD_REF   = 2'h2;
    localparam logic [1:0] CMD_LMR   = 2'h3;
    localparam logic [7:0] TRAP_FETCH = 8'h01;
    localparam logic [7:0] TRAP_LOAD  = 8'h09;
    localparam logic [7:0] TRAP_STORE = 8'h2b;
    // --------------------------------------------------------------
    // Timing and geometry.
    // --------------------------------------------------------------
    localparam logic [3:0]  TRP_SHORT  = 4'h2;
    localparam logic [3:0]  TRP_LONG   = 4'h3;
    localparam logic [3:0]  TRFC_BASE  = 4'h3;
    localparam logic [3:0]  LMR_CYCLES = 4'h2;
    localparam logic [1:0]  CAS_SHORT  = 2'h2;
    localparam logic [1:0]  CAS_LONG   = 2'h3;
    localparam int          CLK_PERIOD_NS     = 20;
    localparam int          REFRESH_PERIOD_NS = 15600;
    localparam logic [9:0]  REFRESH_CYCLES =
        10'(REFRESH_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [31:0] SDRAM_BANK_MIN = 32'h0040_0000;
    localparam logic [31:0] PROM_BANK_BYTES = 32'h0010_0000;
    localparam logic [31:0] PROM_CHECK_BASE =
        PROM_BANK_BYTES - PROM_BANK_BYTES / 5;
    localparam logic [12:0] COLS_256  = 13'h0100;
    localparam logic [12:0] COLS_512  = 13'h0200;
    localparam logic [12:0] COLS_1024 = 13'h0400;
    localparam logic [12:0] COLS_2048 = 13'h0800;
    localparam logic [12:0] COLS_4096 = 13'h1000;
    // --------------------------------------------------------------
    // State types.
    // --------------------------------------------------------------
    typedef enum logic [0:0] {
        ACC_IDLE = 1'b0,
        ACC_WAIT = 1'b1
    } acc_state_t;
    typedef enum logic [0:0] {
        SD_IDLE = 1'b0,
        SD_BUSY = 1'b1
    } sd_state_t;
endpackage

/* verilog/pin_sync.sv */
// Two-stage synchroniser for the external pins of the memory block.
// Assumes the pins are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 4
) (
    // Clock.
    input  wire logic             sys_clk,
    // Pins and synchronised copies.
    input  wire logic [WIDTH-1:0] pin_async,
    output logic      [WIDTH-1:0] pin_sync
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge sys_clk) begin
        meta_q   <= pin_async;
        pin_sync <= meta_q;
    end
endmodule
`default_nettype wire

/* test/ext_mem_model.sv */
// External memory model: ready, error and boot pins.
// Assumes the bench access request on sys_clk.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
    input  wire logic       sys_clk,
    input  wire logic       acc_req,
    input  wire logic       fault,
    input  wire logic [1:0] lag,
    output logic            ext_bus_ready_n,
    output logic            ext_bus_error_n,
    output logic [1:0]      general_purpose_pins
);
    int n;
    assign ext_bus_error_n = !(fault && acc_req && n >= lag);
    assign general_purpose_pins = 2'h2;
    always_ff @(posedge sys_clk) n <= acc_req ? n + 1 : 0;
    // Ready holds until the request drops, well over 1.5 clocks.
    assign ext_bus_ready_n = !(acc_req && n >= lag);
endmodule
`default_nettype wire

/* test/tb_top.sv */
// Bench of the memory configuration block.
// Assumes memcfg and ext_mem_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic sys_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
    logic acc_req = 0, acc_write = 0, acc_fetch = 0, prom_edac_en = 0;
    logic [1:0] acc_area = 0, general_purpose_pins, sdram_cmd, cas_latency;
    logic [31:0] paddr = 0, pwdata = 0, acc_addr = 0, prdata, r, w;
    logic [31:0] m2 = 32'h7c40_0000, sdram_bank_bytes;
    logic [12:0] sdram_columns;
    logic pready, pslverr, ext_bus_ready_n, ext_bus_error_n, acc_done, e;
    logic acc_err, prom_bus_32, io_bus_32, sdram_cmd_strobe, sdram_busy;
    logic sdram_ctrl_en, sram_disable;
    logic acc_trap, tr, fault = 0;
    logic [7:0] acc_trap_code;
    logic [1:0] rcd;
    int errors = 0, n_checks = 0, seed = 32'h51f6, n, q, ws, c, k;
    always #10 sys_clk = ~sys_clk;
    ext_mem_model pm (.sys_clk, .acc_req, .fault, .lag(2'h1), .ext_bus_ready_n,
        .ext_bus_error_n, .general_purpose_pins);
    memcfg uut (.sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext_bus_ready_n, .ext_bus_error_n,
        .general_purpose_pins, .acc_req, .acc_area, .acc_write, .acc_fetch,
        .acc_addr, .prom_edac_en, .acc_done, .acc_err, .acc_trap,
        .acc_trap_code, .prom_bus_32, .io_bus_32, .sdram_cmd_strobe,
        .sdram_cmd, .sdram_busy, .sdram_ctrl_en, .sram_disable, .cas_latency,
        .ras_cas_delay(rcd), .sdram_bank_bytes, .sdram_columns);
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge sys_clk);
        penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        {r, e} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask
    task acc(input logic [1:0] a, input logic wr, output int t);
        @(posedge sys_clk);
        {acc_req, acc_area, acc_write} <= {1'b1, a, wr};
        t = 0;
        do begin
            @(posedge sys_clk);
            t++;
        end while (acc_done !== 1'b1 && t < 99);
        if (t == 99) errors++;
        {e, tr} = {acc_err, acc_trap};
        acc_req <= 0;
    endtask
    task conclude;
        $display("errors=%0d checks=%0d", errors, n_checks);
        if (errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #200us;
        errors++;
        conclude;
    end
    initial begin
        repeat (16) @(posedge sys_clk);
        nrst <= 1;
        apb(0, 0, 0);
        chk(r, 32'h0000_02ff);
        chk(prom_bus_32, 1);
        apb(0, 4, 0);
        chk(r, m2);
        apb(0, 8, 0);
        chk(r, 0);
        chk(e, 1);
        acc(2, 0, n);
        chk(e, 1);
        acc(1, 1, n);
        chk(e, 1);
        for (int i = 0; i < 4; i++) begin
            ws = i == 0 ? 0 : $random(seed) & 15;
            w = 32'h1008_0000 | ws << 20 | ws;
            apb(1, 0, w);
            apb(0, 0, 0);
            chk(r, w);
            acc(2, 0, n);
            acc(1, 0, q);
            chk(n, ws + 3);
            chk(q, 2 * ws + 3);
        end
        chk(io_bus_32, 1);
        prom_edac_en <= 1;
        acc_addr <= 32'h000f_0000;
        acc(1, 0, n);
        chk(e, 1);
        acc_addr <= 0;
        acc(1, 0, n);
        chk(e, 0);
        chk(prom_bus_32, 0);
        apb(1, 0, 32'h4408_0000);
        acc(2, 0, n);
        acc(1, 0, q);
        chk(n, 5);
        chk(q, 5);
        chk(io_bus_32, 0);
        apb(1, 0, 32'h6408_0000);
        acc(2, 0, n);
        chk(n, 6);
        apb(1, 0, 32'h02f8_0000);
        fault <= 1;
        for (int j = 0; j < 3; j++) begin
            acc_fetch <= j == 2;
            acc(2, j == 1, n);
            chk(n, 5);
            chk({e, tr}, 2'h3);
            chk(acc_trap_code,
                j == 0 ? 8'h09 : j == 1 ? 8'h2b : 8'h01);
        end
        for (int i = 0; i < 6; i++) begin
            w = ($random(seed) & 32'h7fe0_2000) | 32'h4000;
            k = w[26] != m2[26] ? 3 : 1 + i % 3;
            apb(1, 4, w | k << 19);
            {n, c} = 0;
            repeat (30) begin
                @(posedge sys_clk);
                n += sdram_busy;
                if (sdram_cmd_strobe) c = sdram_cmd;
            end
            chk(c, k);
            chk(n, k == 1 ? 2 + w[30] : k == 2 ? 3 + w[29:27] : 2);
            apb(0, 4, 0);
            chk(r, w);
            chk(sdram_bank_bytes, 32'h40_0000 << w[25:23]);
            chk(sdram_columns, w[22:21] < 3 ? 256 << w[22:21] :
                w[25:23] == 7 ? 4096 : 2048);
            chk(cas_latency, 2 + w[26]);
            chk(rcd, 2 + w[26]);
            chk({sdram_ctrl_en, sram_disable}, {1'b1, w[13]});
            m2 = w;
        end
        for (int j = 1; j >= 0; j--) begin
            apb(1, 4, m2 | j << 31);
            repeat (4) @(posedge sys_clk);
            c = 0;
            repeat (800) begin
                @(posedge sys_clk);
                c += sdram_cmd_strobe && sdram_cmd == 2;
            end
            chk(c > 0, j);
        end
        conclude;
    end
endmodule
`default_nettype wire
